// file: bench/ivp_core_model.sv
// Core stand-in: fetch address and instruction completions
`timescale 1ns/100ps
module ivp_core_model (
    input  wire logic        clk_sys_i,
    input  wire logic        run_i,
    input  wire logic [16:0] pc_i,
    output logic [16:0]      fetch_pc_o,
    output logic             instr_done_o
);
    logic [1:0] cnt_reg = 2'h0;
    assign fetch_pc_o = pc_i;
    always @(posedge clk_sys_i) begin
        cnt_reg <= cnt_reg + 2'h1;
        instr_done_o <= run_i && cnt_reg == 2'h3;
    end
endmodule // ivp_core_model

// file: bench/ivp_vector_place_sva.sv
// Port assertions for vector placement
`timescale 1ns/100ps
module ivp_vector_place_sva #(parameter ADDR_W = 8, parameter PC_W = 17) (
    input wire logic              clk_sys_i,
    input wire logic              rst_n_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0]        reg_wdata_i,
    input wire logic              reg_wr_i,
    input wire logic              reg_rd_i,
    input wire logic [7:0]        reg_rdata_o,
    input wire logic              boot_reset_fuse_i,
    input wire logic [1:0]        boot_size_fuses_i,
    input wire logic              app_section_lock_bit_i,
    input wire logic              boot_section_lock_bit_i,
    input wire logic [PC_W-1:0]   fetch_pc_i,
    input wire logic              instr_done_i,
    input wire logic [PC_W-1:0]   reset_vector_o,
    input wire logic [PC_W-1:0]   vector_base_o,
    input wire logic              int_block_o,
    input wire logic              global_int_enable_i,
    input wire logic              int_allow_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    wire [PC_W-1:0] bs = 17'h1ffff - (17'h03fff >> boot_size_fuses_i);
    wire wc = reg_wr_i && reg_addr_i == 8'h55;
    wire wun = wc && reg_wdata_i == 8'h01;
    wire wsel = wc && reg_wdata_i[1:0] == 2'b10;
    wire nolk = !app_section_lock_bit_i && !boot_section_lock_bit_i;
    wire alk = app_section_lock_bit_i && fetch_pc_i < bs && vector_base_o != 17'h2;
    wire blk = boot_section_lock_bit_i && fetch_pc_i >= bs && vector_base_o == 17'h2;
    chk_rsvd_zero: assert property ($past(reg_rd_i && reg_addr_i == 8'h55)
        |-> reg_rdata_o[7:2] == 6'h00) else $error("reserved bits set");
    chk_unlock_hold: assert property (wun ##1 !reg_wr_i[*3] |-> int_block_o)
        else $error("block dropped early");
    chk_unlock_end: assert property (wun && nolk ##1 (!reg_wr_i && nolk)[*6]
        |-> !int_block_o) else $error("block stuck");
    chk_reset_vec: assert property ($past(rst_n_i) |-> reset_vector_o ==
        ($past(boot_reset_fuse_i) ? 17'h0 : $past(bs))) else $error("bad reset vector");
    chk_sel_move: assert property (wun ##1 wsel |=> vector_base_o == bs + 17'h2)
        else $error("base not moved");
    chk_block_instr: assert property (wun ##1 (wsel && !instr_done_i)
        ##1 !instr_done_i[*3] |-> int_block_o) else $error("block ended early");
    chk_app_lock: assert property (alk[*3] |-> int_block_o)
        else $error("app lock ignored");
    chk_boot_lock: assert property (blk[*3] |-> int_block_o)
        else $error("boot lock ignored");
    chk_allow_flag: assert property ($past(rst_n_i) |-> int_allow_o ==
        ($past(global_int_enable_i) && !int_block_o)) else $error("allow flag wrong");
endmodule // ivp_vector_place_sva
bind ivp_vector_place ivp_vector_place_sva #(.ADDR_W(ADDR_W), .PC_W(PC_W)) u_sva (.*);

// file: bench/ivp_vector_place_tb.sv
// Testbench for vector placement
`timescale 1ns/100ps
module ivp_vector_place_tb;
    logic clk_sys_i = 0, rst_n_i = 0, wr = 0, rd = 0, brf = 0, alk = 0, blk_b = 0, run = 1;
    logic [7:0] ad = 0, wd = 0, rdat;
    logic [1:0] bsz = 2'h2;
    logic [16:0] pc = 0, fpc, rvec, vb;
    logic done, blk, alw, gie = 1;
    int n_errors = 0, cmp_count = 0, cyc = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    ivp_core_model u_core (.clk_sys_i(clk_sys_i), .run_i(run), .pc_i(pc), .fetch_pc_o(fpc),
        .instr_done_o(done));
    ivp_vector_place u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_addr_i(ad),
        .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
        .boot_reset_fuse_i(brf), .boot_size_fuses_i(bsz), .app_section_lock_bit_i(alk),
        .boot_section_lock_bit_i(blk_b), .fetch_pc_i(fpc), .instr_done_i(done),
        .global_int_enable_i(gie), .reset_vector_o(rvec), .vector_base_o(vb),
        .int_block_o(blk), .int_allow_o(alw));
    task automatic chk(input logic [16:0] s, input logic [16:0] e);
        cmp_count++;
        if (s !== e) begin
            n_errors++;
            $display("wrong value at %0t: %h expected %h", $time, s, e);
        end
    endtask
    task automatic w(input logic [7:0] d);
        @(posedge clk_sys_i);
        {wr, rd, ad, wd} <= {2'b10, 8'h55, d};
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_i) {wr, rd} <= 2'b00;
        #1;
    endtask
    task automatic r(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk_sys_i) {wr, rd, ad} <= {2'b01, a};
        idle(1);
        chk({9'h0, rdat}, {9'h0, e});
    endtask
    task automatic report_and_stop;
        if (n_errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            report_and_stop;
        end
    end
    initial begin
        repeat (5) @(posedge clk_sys_i);
        rst_n_i <= 1;
        idle(2);
        chk(rvec, 17'h1f000);
        w(8'h0e);
        r(8'h55, 8'h00);
        r(8'h57, 8'h00);
        w(8'h01);
        idle(3);
        r(8'h55, 8'h01);
        r(8'h55, 8'h00);
        idle(6);
        chk({16'h0, alw}, 17'h1);
        gie <= 0;
        idle(2);
        chk({16'h0, alw}, 17'h0);
        gie <= 1;
        w(8'h02);
        r(8'h55, 8'h00);
        run <= 0;
        w(8'h01);
        w(8'h02);
        idle(5);
        chk({16'h0, blk}, 17'h1);
        run <= 1;
        idle(8);
        chk({16'h0, blk}, 17'h0);
        for (int i = 0; i < 8; i++) begin
            {brf, bsz} <= i[2:0];
            w(8'h01);
            w(8'h02);
            idle(8);
            chk(vb, 17'h1ffff - (17'h03fff >> i[1:0]) + 17'h2);
            chk(rvec, i[2] ? 17'h0 : 17'h1ffff - (17'h03fff >> i[1:0]));
            w(8'h01);
            w(8'h00);
            idle(8);
            chk(vb, 17'h2);
        end
        {brf, bsz, pc} <= {3'h2, 17'h00100};
        w(8'h01);
        w(8'h02);
        alk <= 1;
        idle(8);
        chk({16'h0, blk}, 17'h1);
        {alk, blk_b} <= 2'b01;
        w(8'h01);
        w(8'h00);
        idle(8);
        chk({16'h0, blk}, 17'h0);
        pc <= 17'h1f010;
        idle(5);
        chk({16'h0, blk}, 17'h1);
        report_and_stop;
    end
endmodule // ivp_vector_place_tb

// file: hw/ivp_regs.vh
// Register offsets, field positions, reset values and timing counts for vector placement
`ifndef IVP_REGS_VH
`define IVP_REGS_VH

`define IVP_CTRL_OFFSET      8'h55
`define IVP_CTRL_RESET       8'h00
`define IVP_UNLOCK_BIT       0
`define IVP_SELECT_BIT       1
`define IVP_RSVD_MSB         3
`define IVP_RSVD_LSB         2

`define IVP_STATUS_OFFSET    8'h56
`define IVP_STATUS_ACT_BIT   4
`define IVP_STATUS_CNT_MSB   2

`define IVP_UNLOCK_CYCLES    3'h4
`define IVP_APP_BASE         17'h00000
`define IVP_VECTOR_OFFSET    17'h00002
`define IVP_BOOT_START_SZ0   17'h1c000
`define IVP_BOOT_START_SZ1   17'h1e000
`define IVP_BOOT_START_SZ2   17'h1f000
`define IVP_BOOT_START_SZ3   17'h1f800

`endif

// file: hw/ivp_vector_place.v
// Interrupt vector placement: select bit with timed unlock, vector bases, lock gating
//
// Notes on behaviour
// - Select bit zero puts the vector table at flash start.
// - Select bit one moves the vector table to the boot section start.
// - Boot section start, and relocated base, follow the boot size fuses.
// - A new select value is taken only after unlock was written to one.
// - Unlock clears four cycles after set, or at once when select is written.
// - Interrupts blocked from unlock set until after the instruction after select write.
// - Without a select write, interrupts stay blocked four cycles then resume.
// - Automatic blocking leaves the global interrupt enable flag untouched.
// - Vectors in boot and app lock bit programmed: block interrupts in app code.
// - Vectors in app and boot lock bit programmed: block interrupts in boot code.
// - Boot reset fuse programmed, select clear: reset at boot start, vectors at 0x0002.
// - Boot reset fuse programmed, select set: vectors at boot start plus 0x0002.
// - Boot reset fuse unprogrammed: reset at 0x0000, vectors placed per select.
//
// The strobed register port was left to the implementer.
`timescale 1ns/100ps
`include "ivp_regs.vh"

module ivp_vector_place #(
    parameter ADDR_W = 8,
    parameter PC_W   = 17
) (
    input  wire              clk_sys_i,
    input  wire              rst_n_i,
    input  wire [ADDR_W-1:0] reg_addr_i,
    input  wire [7:0]        reg_wdata_i,
    input  wire              reg_wr_i,
    input  wire              reg_rd_i,
    output reg  [7:0]        reg_rdata_o,
    input  wire              boot_reset_fuse_i,
    input  wire [1:0]        boot_size_fuses_i,
    input  wire              app_section_lock_bit_i,
    input  wire              boot_section_lock_bit_i,
    input  wire [PC_W-1:0]   fetch_pc_i,
    input  wire              instr_done_i,
    input  wire              global_int_enable_i,
    output reg  [PC_W-1:0]   reset_vector_o,
    output reg  [PC_W-1:0]   vector_base_o,
    output reg               int_block_o,
    output reg               int_allow_o
);

    // =====================================================================
    // Boot section start from fuses
    // =====================================================================
    reg [PC_W-1:0] boot_start;

    always @* begin
        case (boot_size_fuses_i)
            2'h0: begin
                boot_start = `IVP_BOOT_START_SZ0;
            end
            2'h1: begin
                boot_start = `IVP_BOOT_START_SZ1;
            end
            2'h2: begin
                boot_start = `IVP_BOOT_START_SZ2;
            end
            default: begin
                boot_start = `IVP_BOOT_START_SZ3;
            end
        endcase
    end

    // =====================================================================
    // Control register and unlock sequence
    // =====================================================================
    localparam ST_IDLE   = 2'h0;
    localparam ST_OPEN   = 2'h1;
    localparam ST_TRAIL  = 2'h2;

    reg       select_reg;
    reg       select_next;
    reg       unlock_reg;
    reg       unlock_next;
    reg [2:0] unlock_cnt_reg;
    reg [2:0] unlock_cnt_next;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg       ctrl_wr;

    always @* begin
        ctrl_wr         = reg_wr_i && (reg_addr_i == `IVP_CTRL_OFFSET);
        select_next     = select_reg;
        unlock_next     = unlock_reg;
        unlock_cnt_next = unlock_cnt_reg;
        state_next      = state_reg;
        case (state_reg)
            ST_IDLE: begin
                if (ctrl_wr && reg_wdata_i[`IVP_UNLOCK_BIT]) begin
                    unlock_next     = 1'b1;
                    unlock_cnt_next = `IVP_UNLOCK_CYCLES;
                    state_next      = ST_OPEN;
                end
                // Select writes without unlock are dropped
            end
            ST_OPEN: begin
                if (ctrl_wr && !reg_wdata_i[`IVP_UNLOCK_BIT]) begin
                    select_next = reg_wdata_i[`IVP_SELECT_BIT];
                    unlock_next = 1'b0;
                    state_next  = ST_TRAIL;
                end else if (unlock_cnt_reg == 3'h1) begin
                    unlock_next     = 1'b0;
                    unlock_cnt_next = 3'h0;
                    state_next      = ST_IDLE;
                end else begin
                    unlock_cnt_next = unlock_cnt_reg - 3'h1;
                end
            end
            ST_TRAIL: begin
                // Hold off until the following instruction completes
                if (instr_done_i) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next  = ST_IDLE;
                unlock_next = 1'b0;
            end
        endcase
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            select_reg <= 1'b0;
        end else begin
            select_reg <= select_next;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            unlock_reg <= 1'b0;
        end else begin
            unlock_reg <= unlock_next;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            unlock_cnt_reg <= 3'h0;
        end else begin
            unlock_cnt_reg <= unlock_cnt_next;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // =====================================================================
    // Execution region of the current fetch
    // =====================================================================
    reg in_boot;
    reg in_app;

    always @* begin
        if (fetch_pc_i >= boot_start) begin
            in_boot = 1'b1;
            in_app  = 1'b0;
        end else begin
            in_boot = 1'b0;
            in_app  = 1'b1;
        end
    end

    // =====================================================================
    // Sequence blocking
    // =====================================================================
    reg seq_block;

    always @* begin
        // Blocked from the cycle unlock is written
        case (state_next)
            ST_OPEN:  seq_block = 1'b1;
            ST_TRAIL: seq_block = 1'b1;
            default:  seq_block = 1'b0;
        endcase
    end

    // =====================================================================
    // Boot lock gating
    // =====================================================================
    // Lock terms follow the select value being loaded
    reg app_lock_block;
    reg boot_lock_block;
    reg lock_block;

    always @* begin
        app_lock_block = 1'b0;
        if (select_next && app_section_lock_bit_i) begin
            if (in_app) begin
                app_lock_block = 1'b1;
            end
        end
    end

    always @* begin
        boot_lock_block = 1'b0;
        if (!select_next && boot_section_lock_bit_i) begin
            if (in_boot) begin
                boot_lock_block = 1'b1;
            end
        end
    end

    always @* begin
        lock_block = app_lock_block || boot_lock_block;
    end

    // =====================================================================
    // Vector base and reset address
    // =====================================================================
    reg [PC_W-1:0] base_next;
    reg [PC_W-1:0] rst_vec_next;

    always @* begin
        if (select_next) begin
            base_next = boot_start + `IVP_VECTOR_OFFSET;
        end else begin
            base_next = `IVP_APP_BASE + `IVP_VECTOR_OFFSET;
        end
    end

    always @* begin
        if (!boot_reset_fuse_i) begin
            rst_vec_next = boot_start;
        end else begin
            rst_vec_next = `IVP_APP_BASE;
        end
    end

    // =====================================================================
    // Interrupt gating terms
    // =====================================================================
    reg block_next;
    reg allow_next;

    always @* begin
        block_next = seq_block || lock_block;
    end

    always @* begin
        // Global enable is only read, never altered
        allow_next = global_int_enable_i && !block_next;
    end

    // =====================================================================
    // Registered outputs
    // =====================================================================
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reset_vector_o <= {PC_W{1'b0}};
        end else begin
            reset_vector_o <= rst_vec_next;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vector_base_o <= `IVP_VECTOR_OFFSET;
        end else begin
            vector_base_o <= base_next;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_block_o <= 1'b0;
        end else begin
            int_block_o <= block_next;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            int_allow_o <= 1'b0;
        end else begin
            int_allow_o <= allow_next;
        end
    end

    // =====================================================================
    // Register read port
    // =====================================================================
    reg       ctrl_rd;
    reg       status_rd;
    reg       seq_active;
    reg [7:0] ctrl_view;
    reg [7:0] status_view;
    reg [7:0] rdata_next;

    always @* begin
        ctrl_rd = reg_rd_i && (reg_addr_i == `IVP_CTRL_OFFSET);
    end

    always @* begin
        status_rd = reg_rd_i && (reg_addr_i == `IVP_STATUS_OFFSET);
    end

    always @* begin
        seq_active = (state_reg != ST_IDLE);
    end

    always @* begin
        // Reserved and foreign bits read zero
        ctrl_view                  = 8'h00;
        ctrl_view[`IVP_UNLOCK_BIT] = unlock_reg;
        ctrl_view[`IVP_SELECT_BIT] = select_reg;
    end

    always @* begin
        status_view                                = 8'h00;
        status_view[`IVP_STATUS_ACT_BIT]           = seq_active;
        status_view[`IVP_STATUS_CNT_MSB:0]         = unlock_cnt_reg;
    end

    always @* begin
        if (ctrl_rd) begin
            rdata_next = ctrl_view;
        end else if (status_rd) begin
            rdata_next = status_view;
        end else begin
            rdata_next = 8'h00;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            reg_rdata_o <= `IVP_CTRL_RESET;
        end else begin
            reg_rdata_o <= rdata_next;
        end
    end

endmodule // ivp_vector_place
